// >>> inc/rbw_params.svh
/*
 Timing and reset constants for the relay board watchdog and status LEDs.
 Assumes a 10 MHz reference clock.
*/
`ifndef RBW_PARAMS_SVH
`define RBW_PARAMS_SVH
// ----------------------------------------------------------------
// Clock and timeout
// ----------------------------------------------------------------
`define RBW_CLK_HZ 10_000_000
`define RBW_TIMEOUT_S 30
`define RBW_TIMEOUT_CYC (`RBW_TIMEOUT_S * `RBW_CLK_HZ)
`define RBW_CNT_W 32
`define RBW_CNT_ZERO 32'h0000_0000
`define RBW_CNT_ONE 32'h0000_0001
`define RBW_BIT_OFF 1'h0
// ----------------------------------------------------------------
// Bit positions and masks
// ----------------------------------------------------------------
`define RBW_IN_WDOG 0
`define RBW_IN_FIRST_CMD 1
`define RBW_IN_LAST_CMD 9
`define RBW_IN_PHOT_FIT 10
`define RBW_IN_OZG_FIT 11
`define RBW_B_MR 0
`define RBW_B_OV 1
`define RBW_B_PU 2
`define RBW_B_TI 3
`define RBW_B_DI 4
`define RBW_B_CG 5
`define RBW_B_PH 6
`define RBW_B_OH 7
`define RBW_B_LA 8
// Only the pump survives a trip; it is neither valve, heater nor lamp
`define RBW_TRIP_KEEP 9'h004
`define RBW_DRV_OFF 9'h000
`define RBW_IND_OFF 8'h00
`endif

// >>> inc/rbw_pkg.sv
/*
 Types for the relay board watchdog block.
 Assumes rbw_params.svh is on the include path.
*/
`include "rbw_params.svh"
package rbw_pkg;
   typedef enum logic {RBW_RUN, RBW_TRIPPED} rbw_state_t;
   typedef logic [`RBW_CNT_W-1:0] rbw_cnt_t;
endpackage : rbw_pkg

// >>> rtl/rbw_sync.sv
/*
 Two flip-flop synchroniser for one level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rbw_params.svh"
module rbw_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_reg;
   logic meta_next;
   logic q_reg;
   logic q_next;

   always_comb begin
      meta_next = d;
      q_next = meta_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= `RBW_BIT_OFF;
         q_reg <= `RBW_BIT_OFF;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule : rbw_sync
`default_nettype wire

// >>> rtl/rbw_top.sv
/*
 Relay board watchdog monitor and status indicator drive.
 Assumes host commands arrive as levels from an I2C port expander
 in another domain, option straps are static, one 10 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rbw_params.svh"
// Overview of operation
// - Watchdog indicator follows host written level
// - Trip after level held for timeout
// - Trip closes valves, heaters and lamps off
// - Pump indicator mirrors pump drive when photometer fitted
// - Diluent, cal gas indicators mirror valves
// - Titration indicator mirrors titration chamber valve when either option fitted
// - Heater indicators mirror their heater drives when their own option is fitted
// - Option indicators gated by fitted options
module rbw_top #(
   // Trip time in clocks; a bench may shorten it to reach a trip
   parameter int TIMEOUT_CYC = `RBW_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic host_wdog,
   input wire logic host_meas_ref_valve,
   input wire logic host_ozone_gen_valve,
   input wire logic host_pump,
   input wire logic host_titration_valve,
   input wire logic host_diluent_valve,
   input wire logic host_cal_gas_valve,
   input wire logic host_photometer_heater,
   input wire logic host_ozone_gen_heater,
   input wire logic host_lamp,
   input wire logic photometer_fitted,
   input wire logic ozone_gen_fitted,
   output logic watchdog_indicator,
   output logic tripped,
   output logic meas_ref_valve_drive,
   output logic ozone_gen_valve_drive,
   output logic pump_drive,
   output logic titration_valve_drive,
   output logic diluent_valve_drive,
   output logic cal_gas_valve_drive,
   output logic photometer_heater_drive,
   output logic ozone_gen_heater_drive,
   output logic lamp_drive,
   output logic meas_ref_valve_indicator,
   output logic ozone_gen_valve_indicator,
   output logic pump_indicator,
   output logic titration_valve_indicator,
   output logic diluent_valve_indicator,
   output logic cal_gas_valve_indicator,
   output logic photometer_heater_indicator,
   output logic ozone_gen_heater_indicator
);
   import rbw_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NIN = 12;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync_in;

   assign raw_in = {ozone_gen_fitted, photometer_fitted, host_lamp,
      host_ozone_gen_heater, host_photometer_heater, host_cal_gas_valve,
      host_diluent_valve, host_titration_valve, host_pump,
      host_ozone_gen_valve, host_meas_ref_valve, host_wdog};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         rbw_sync u_sync (
            .clk(ref_clk),
            .rst(rst),
            .d(raw_in[gi]),
            .q(sync_in[gi])
         );
      end
   endgenerate

   logic wdog_s;
   logic phot_fit_s;
   logic ozg_fit_s;
   assign wdog_s = sync_in[`RBW_IN_WDOG];
   assign phot_fit_s = sync_in[`RBW_IN_PHOT_FIT];
   assign ozg_fit_s = sync_in[`RBW_IN_OZG_FIT];

   // ----------------------------------------------------------------
   // Watchdog monitor
   // ----------------------------------------------------------------
   // Trip latches until reset: a stalled host must not re-open valves
   // just by blinking again without a restart.
   rbw_state_t state_reg;
   rbw_state_t state_next;
   rbw_cnt_t cnt_reg;
   rbw_cnt_t cnt_next;
   logic wdog_reg;
   logic wdog_next;

   always_comb begin
      state_next = state_reg;
      wdog_next = wdog_s;
      cnt_next = cnt_reg;
      case (state_reg)
         RBW_RUN: begin
            if (wdog_s != wdog_reg) begin
               cnt_next = `RBW_CNT_ZERO;
            end else if (cnt_reg >= rbw_cnt_t'(TIMEOUT_CYC - 1)) begin
               state_next = RBW_TRIPPED;
            end else begin
               cnt_next = cnt_reg + `RBW_CNT_ONE;
            end
         end
         RBW_TRIPPED: begin
            state_next = RBW_TRIPPED;
         end
         default: begin
            state_next = RBW_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= RBW_RUN;
         cnt_reg <= `RBW_CNT_ZERO;
         wdog_reg <= `RBW_BIT_OFF;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         wdog_reg <= wdog_next;
      end
   end

   // ----------------------------------------------------------------
   // Drives and indicators
   // ----------------------------------------------------------------
   // Drive and indicator bits sit at the RBW_B_* positions
   localparam int ND = 9;
   localparam int NI = 8;
   logic [ND-1:0] drv_reg;
   logic [ND-1:0] drv_next;
   logic [NI-1:0] ind_reg;
   logic [NI-1:0] ind_next;
   logic wdi_reg;
   logic wdi_next;
   logic trip_reg;
   logic trip_next;
   logic trip_now;

   always_comb begin
      trip_now = (state_next == RBW_TRIPPED);
      trip_next = trip_now;
      wdi_next = wdog_s;
      drv_next = sync_in[`RBW_IN_LAST_CMD:`RBW_IN_FIRST_CMD];
      if (trip_now) begin
         // Pump is left to the host; only valves, heaters, lamp forced
         drv_next = drv_next & `RBW_TRIP_KEEP;
      end
      // The lamp drive has no indicator, so it is not carried here
      ind_next = drv_next[NI-1:0];
      ind_next[`RBW_B_MR] = drv_next[`RBW_B_MR] & phot_fit_s;
      ind_next[`RBW_B_PU] = drv_next[`RBW_B_PU] & phot_fit_s;
      ind_next[`RBW_B_PH] = drv_next[`RBW_B_PH] & phot_fit_s;
      ind_next[`RBW_B_OV] = drv_next[`RBW_B_OV] & ozg_fit_s;
      ind_next[`RBW_B_OH] = drv_next[`RBW_B_OH] & ozg_fit_s;
      ind_next[`RBW_B_TI] = drv_next[`RBW_B_TI] &
         (phot_fit_s | ozg_fit_s);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drv_reg <= `RBW_DRV_OFF;
         ind_reg <= `RBW_IND_OFF;
         wdi_reg <= `RBW_BIT_OFF;
         trip_reg <= `RBW_BIT_OFF;
      end else begin
         drv_reg <= drv_next;
         ind_reg <= ind_next;
         wdi_reg <= wdi_next;
         trip_reg <= trip_next;
      end
   end

   assign watchdog_indicator = wdi_reg;
   assign tripped = trip_reg;
   assign meas_ref_valve_drive = drv_reg[`RBW_B_MR];
   assign ozone_gen_valve_drive = drv_reg[`RBW_B_OV];
   assign pump_drive = drv_reg[`RBW_B_PU];
   assign titration_valve_drive = drv_reg[`RBW_B_TI];
   assign diluent_valve_drive = drv_reg[`RBW_B_DI];
   assign cal_gas_valve_drive = drv_reg[`RBW_B_CG];
   assign photometer_heater_drive = drv_reg[`RBW_B_PH];
   assign ozone_gen_heater_drive = drv_reg[`RBW_B_OH];
   assign lamp_drive = drv_reg[`RBW_B_LA];
   assign meas_ref_valve_indicator = ind_reg[`RBW_B_MR];
   assign ozone_gen_valve_indicator = ind_reg[`RBW_B_OV];
   assign pump_indicator = ind_reg[`RBW_B_PU];
   assign titration_valve_indicator = ind_reg[`RBW_B_TI];
   assign diluent_valve_indicator = ind_reg[`RBW_B_DI];
   assign cal_gas_valve_indicator = ind_reg[`RBW_B_CG];
   assign photometer_heater_indicator = ind_reg[`RBW_B_PH];
   assign ozone_gen_heater_indicator = ind_reg[`RBW_B_OH];
endmodule : rbw_top
`default_nettype wire

// >>> sim/rbw_host_model.sv
/*
 Host side model: sets the watchdog level the way the host would.
 Assumes one ref_clk and an active high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module rbw_host_model #(
   parameter int HALF = 20
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run,
   output logic host_wdog
);
   int cnt;
   // Toggles while healthy; run low mimics a hung host
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         host_wdog <= 1'h0;
      end else if (run) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) host_wdog <= ~host_wdog;
      end
   end
endmodule : rbw_host_model
`default_nettype wire

// >>> sim/rbw_top_assertions.sv
/*
 Checker on the ports of rbw_top.
 Assumes one clock domain and async active high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module rbw_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic host_wdog,
   input wire logic photometer_fitted,
   input wire logic ozone_gen_fitted,
   input wire logic watchdog_indicator,
   input wire logic tripped,
   input wire logic meas_ref_valve_drive,
   input wire logic pump_drive,
   input wire logic titration_valve_drive,
   input wire logic diluent_valve_drive,
   input wire logic photometer_heater_drive,
   input wire logic lamp_drive,
   input wire logic meas_ref_valve_indicator,
   input wire logic pump_indicator,
   input wire logic titration_valve_indicator,
   input wire logic diluent_valve_indicator,
   input wire logic photometer_heater_indicator
);
   logic [2:0] up_reg;
   logic [2:0] up_next;
   // Cycles since reset, so the $past in wdog_follow_a never reaches into reset
   always_comb up_next = (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) up_reg <= 3'h0;
      else up_reg <= up_next;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wdog_follow_a: assert property (
      up_reg == 3'h4 |-> watchdog_indicator == $past(host_wdog, 3))
      else $error("watchdog indicator lag wrong");
   // Straps reach the indicators three clocks late, like the drives
   pump_ind_a: assert property (
      pump_indicator == (pump_drive & $past(photometer_fitted, 3)))
      else $error("pump indicator wrong");
   diluent_ind_a: assert property (
      diluent_valve_indicator == diluent_valve_drive)
      else $error("diluent indicator wrong");
   titration_ind_a: assert property (
      titration_valve_indicator == (titration_valve_drive &
      ($past(photometer_fitted, 3) | $past(ozone_gen_fitted, 3))))
      else $error("titration indicator wrong");
   heater_ind_a: assert property (
      photometer_heater_indicator ==
      (photometer_heater_drive & $past(photometer_fitted, 3)))
      else $error("heater indicator wrong");
   meas_ref_a: assert property (
      meas_ref_valve_indicator ==
      (meas_ref_valve_drive & $past(photometer_fitted, 3)))
      else $error("meas ref indicator wrong");
   trip_off_a: assert property (
      tripped |-> !(diluent_valve_drive | lamp_drive |
      photometer_heater_drive | titration_valve_drive))
      else $error("output on after trip");
   toggle_restart_a: assert property (
      $changed(watchdog_indicator) && !tripped |=> !tripped [*8])
      else $error("trip right after toggle");
endmodule : rbw_checker
`default_nettype wire

// >>> sim/relay_board_watchdog_status_bench.sv
/*
 Self-checking bench for rbw_top with a host model.
 Assumes the top's trip timeout is cut short, so a trip is reached.
*/
`timescale 1ns/100ps
`default_nettype none
module relay_board_watchdog_status_bench;
   // The real 30 s would take far too long; the trip logic is the same
   localparam int TRIP_CYC = 400;
   logic ref_clk, rst, host_wdog, run, pf, of, watchdog_indicator, tripped;
   logic [8:0] cmd, drv, st, ind9;
   logic [7:0] ind;
   logic [2:0] wd_h;
   int mismatches, checked;
   assign st = {tripped, 7'h00, watchdog_indicator};
   assign ind9 = {1'h0, ind};
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) wd_h <= {wd_h[1:0], host_wdog};
   rbw_host_model host (.ref_clk(ref_clk), .rst(rst), .run(run),
      .host_wdog(host_wdog));
   rbw_top #(.TIMEOUT_CYC(TRIP_CYC)) dut (.ref_clk(ref_clk), .rst(rst),
      .host_wdog(host_wdog),
      .host_meas_ref_valve(cmd[0]), .host_ozone_gen_valve(cmd[1]),
      .host_pump(cmd[2]), .host_titration_valve(cmd[3]),
      .host_diluent_valve(cmd[4]), .host_cal_gas_valve(cmd[5]),
      .host_photometer_heater(cmd[6]), .host_ozone_gen_heater(cmd[7]),
      .host_lamp(cmd[8]), .photometer_fitted(pf), .ozone_gen_fitted(of),
      .watchdog_indicator(watchdog_indicator), .tripped(tripped),
      .meas_ref_valve_drive(drv[0]), .ozone_gen_valve_drive(drv[1]),
      .pump_drive(drv[2]), .titration_valve_drive(drv[3]),
      .diluent_valve_drive(drv[4]), .cal_gas_valve_drive(drv[5]),
      .photometer_heater_drive(drv[6]), .ozone_gen_heater_drive(drv[7]),
      .lamp_drive(drv[8]), .meas_ref_valve_indicator(ind[0]),
      .ozone_gen_valve_indicator(ind[1]), .pump_indicator(ind[2]),
      .titration_valve_indicator(ind[3]), .diluent_valve_indicator(ind[4]),
      .cal_gas_valve_indicator(ind[5]), .photometer_heater_indicator(ind[6]),
      .ozone_gen_heater_indicator(ind[7]));
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apply(input logic [8:0] c, input logic [1:0] o);
      @(posedge ref_clk);
      cmd <= c;
      {of, pf} <= o;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : apply
   task automatic give_verdict;
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial begin
      logic [8:0] c;
      logic [8:0] e;
      ref_clk = 1'h0;
      rst = 1'h1;
      run = 1'h1;
      cmd = 9'h000;
      pf = 1'h0;
      of = 1'h0;
      mismatches = 0;
      checked = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 10; b++) begin
            c = (b == 9) ? 9'h1ff : 9'h001 << b;
            apply(c, m[1:0]);
            e = {1'h0, of & c[7], pf & c[6], c[5], c[4], (pf | of) & c[3],
               pf & c[2], of & c[1], pf & c[0]};
            check(drv, c);
            check(ind9, e);
            check(st, {1'h0, 7'h00, wd_h[2]});
         end
      end
      // Hung host: the level holds, still short of the timeout
      run <= 1'h0;
      repeat (300) @(posedge ref_clk);
      @(negedge ref_clk);
      check(st, {1'h0, 7'h00, host_wdog});
      // Reset with the host still hung: timing starts again from zero
      @(posedge ref_clk);
      rst <= 1'h1;
      @(negedge ref_clk);
      check(drv | {tripped, ind}, 9'h000);
      @(posedge ref_clk);
      rst <= 1'h0;
      apply(9'h1ff, 2'h3);
      repeat (TRIP_CYC - 7) @(posedge ref_clk);
      @(negedge ref_clk);
      check(st, 9'h000);
      check(drv, 9'h1ff);
      @(negedge ref_clk);
      check(st, 9'h100);
      check(drv, 9'h004);
      check(ind9, 9'h004);
      // A host that blinks again does not undo the trip
      @(posedge ref_clk);
      run <= 1'h1;
      repeat (60) @(posedge ref_clk);
      @(negedge ref_clk);
      check(st, {1'h1, 7'h00, wd_h[2]});
      check(drv, 9'h004);
      @(posedge ref_clk);
      rst <= 1'h1;
      @(posedge ref_clk);
      rst <= 1'h0;
      apply(9'h010, 2'h0);
      check(drv, 9'h010);
      check(st, {1'h0, 7'h00, wd_h[2]});
      give_verdict();
   end
   initial begin
      #2_000_000;
      mismatches++;
      give_verdict();
   end
endmodule : relay_board_watchdog_status_bench
bind rbw_top rbw_checker chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .host_wdog(host_wdog),
   .photometer_fitted(photometer_fitted),
   .ozone_gen_fitted(ozone_gen_fitted),
   .watchdog_indicator(watchdog_indicator),
   .tripped(tripped),
   .meas_ref_valve_drive(meas_ref_valve_drive),
   .pump_drive(pump_drive),
   .titration_valve_drive(titration_valve_drive),
   .diluent_valve_drive(diluent_valve_drive),
   .photometer_heater_drive(photometer_heater_drive),
   .lamp_drive(lamp_drive),
   .meas_ref_valve_indicator(meas_ref_valve_indicator),
   .pump_indicator(pump_indicator),
   .titration_valve_indicator(titration_valve_indicator),
   .diluent_valve_indicator(diluent_valve_indicator),
   .photometer_heater_indicator(photometer_heater_indicator)
);
`default_nettype wire
